// >>> pkg/mbpwm_pkg.sv
package mbpwm_pkg;

	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int unsigned MATCH_N = 7;
	localparam int unsigned CAP_MAX = 4;
	localparam int unsigned EXT_N = 4;
	localparam int unsigned ADDR_W = 8;

	// ----------------------------------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_COUNT = 8'h04;
	localparam logic [7:0] OFF_PRESCALE = 8'h08;
	localparam logic [7:0] OFF_PRECOUNT = 8'h0C;
	localparam logic [7:0] OFF_MATCH_CTRL = 8'h10;
	localparam logic [7:0] OFF_COUNT_CTRL = 8'h14;
	localparam logic [7:0] OFF_CAP_CTRL = 8'h18;
	localparam logic [7:0] OFF_EXT_MATCH = 8'h1C;
	localparam logic [7:0] OFF_PWM_CTRL = 8'h20;
	localparam logic [7:0] OFF_RELEASE = 8'h24;
	localparam logic [7:0] OFF_FLAGS = 8'h28;
	localparam logic [7:0] OFF_MATCH_BASE = 8'h40;
	localparam logic [7:0] OFF_CAP_BASE = 8'h60;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int unsigned CTRL_RUN = 0;
	localparam int unsigned CTRL_CLR = 1;
	localparam int unsigned CTRL_PWM = 2;
	localparam int unsigned CTRL_FOLLOW = 3;
	localparam int unsigned MCR_INT = 0;
	localparam int unsigned MCR_RST = 1;
	localparam int unsigned MCR_STOP = 2;
	localparam int unsigned MCR_STRIDE = 3;
	localparam int unsigned CCR_RISE = 0;
	localparam int unsigned CCR_FALL = 1;
	localparam int unsigned CCR_INT = 2;
	localparam int unsigned CCR_STRIDE = 3;
	localparam int unsigned CNT_MODE_POS = 0;
	localparam int unsigned CNT_SEL_POS = 2;
	localparam int unsigned EMR_ACT_POS = 4;
	localparam int unsigned PWM_DBL_POS = 0;
	localparam int unsigned PWM_EN_POS = 8;
	localparam int unsigned FLAG_CAP_POS = 7;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] RST_WORD = 32'h0000_0000;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CNT_TIMER = 2'h0,
		CNT_RISE = 2'h1,
		CNT_FALL = 2'h2,
		CNT_BOTH = 2'h3
	} mbpwm_cnt_type;

	typedef enum logic [1:0] {
		EXT_KEEP = 2'h0,
		EXT_LOW = 2'h1,
		EXT_HIGH = 2'h2,
		EXT_TOGGLE = 2'h3
	} mbpwm_ext_type;

	typedef enum logic [0:0] {
		BUS_IDLE = 1'b0,
		BUS_ACK = 1'b1
	} mbpwm_bus_type;

	typedef struct packed {
		logic read;
		logic write;
		logic [ADDR_W-1:0] address;
		logic [3:0] byteenable;
		logic [31:0] writedata;
	} mbpwm_avreq_type;

	// byte-lane merge of a bus write into an old word
	function automatic logic [31:0] merge_bytes(input logic [31:0] old,
		input logic [31:0] wdat, input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				res[8*b +: 8] = wdat[8*b +: 8];
			end
		end
		return res;
	endfunction : merge_bytes

endpackage : mbpwm_pkg

// >>> hw/mbpwm_match_bank.sv
`timescale 1ns/1ps
module mbpwm_match_bank (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic wr_i,
	input wire logic [2:0] idx_i,
	input wire logic [31:0] data_i,
	input wire logic [3:0] be_i,
	input wire logic rel_wr_i,
	input wire logic [mbpwm_pkg::MATCH_N-1:0] rel_i,
	input wire logic apply_i,
	input wire logic now_i,
	output logic [mbpwm_pkg::MATCH_N-1:0][31:0] shadow_o,
	output logic [mbpwm_pkg::MATCH_N-1:0][31:0] active_o,
	output logic [mbpwm_pkg::MATCH_N-1:0] pending_o
);
	import mbpwm_pkg::*;

	logic [MATCH_N-1:0] rel_clr;

	// ----------------------------------------------------------------
	// shadow, release and active copies
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			shadow_o <= '0;
		end else if (wr_i && int'(idx_i) < MATCH_N) begin
			shadow_o[idx_i] <= merge_bytes(shadow_o[idx_i], data_i, be_i);
		end
	end

	assign rel_clr = (apply_i && !now_i) ? pending_o : '0;

	// a new release wins over the clear of the same cycle
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			pending_o <= '0;
		end else begin
			pending_o <= (pending_o & ~rel_clr) | (rel_wr_i ? rel_i : '0); // R13
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			active_o <= '0;
		end else begin
			for (int i = 0; i < MATCH_N; i++) begin
				if (now_i) begin
					active_o[i] <= shadow_o[i]; // R14
				end else if (apply_i && pending_o[i]) begin
					active_o[i] <= shadow_o[i]; // R13
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_release_applies: assert property (@(posedge mclk_i) disable iff (rst_i) // R13
		apply_i && !now_i && pending_o[1] |=> active_o[1] == $past(shadow_o[1]))
		else $error("released match value not applied at cycle start");

	a_unreleased_held: assert property (@(posedge mclk_i) disable iff (rst_i) // R13
		!now_i && !pending_o[1] |=> active_o[1] == $past(active_o[1]))
		else $error("match value changed without release");

endmodule : mbpwm_match_bank

// >>> hw/mbpwm_top.sv
// The address map and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// R01 - 32-bit counter advanced through a programmable 32-bit prescaler.
// R02 - prescaler hits its limit: count steps by one, prescaler restarts at zero.
// R03 - count peripheral clocks, or edges of a selected capture input.
// R04 - seven matches: six single-edge, three double-edge outputs, or a mix.
// R05 - each match may flag, and may keep counting, stop or reset.
// R06 - match zero sets the cycle length and clears the count.
// R07 - single-edge outputs rise at cycle start unless held constantly low.
// R08 - one extra match per single-edge output sets its falling edge.
// R09 - double-edge outputs use two matches: rising and falling edge.
// R10 - double-edge edges may sit anywhere inside the cycle.
// R11 - rise before fall gives positive pulse, fall first gives negative.
// R12 - period and width in any count, one shared repetition rate.
// R13 - new matches apply only once released, at the cycle start.
// R14 - without modulation mode the block is a plain match/capture timer.
// R15 - two instances run locked: primary leads, secondary follows its enable.
// R16 - capture input transition copies the count into its capture register.
// R17 - external match outputs go low, high, toggle or stay on match.
module mbpwm_top #(
	parameter int unsigned CAP_N = 4
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire mbpwm_pkg::mbpwm_avreq_type av_i,
	output logic [31:0] av_readdata_o,
	output logic av_waitrequest_o,
	input wire logic [CAP_N-1:0] cap_i,
	input wire logic sync_run_i,
	output logic sync_run_o,
	output logic [mbpwm_pkg::MATCH_N-2:0] pwm_o,
	output logic [mbpwm_pkg::EXT_N-1:0] ext_match_o,
	output logic attn_o
);
	import mbpwm_pkg::*;

	localparam int unsigned FLAG_W = FLAG_CAP_POS + CAP_MAX;

	if (CAP_N < 1 || CAP_N > CAP_MAX) begin : g_cap_check
		$error("CAP_N must lie between 1 and 4");
	end

	// ----------------------------------------------------------------
	// registers and internal signals
	// ----------------------------------------------------------------
	mbpwm_bus_type bus_state;
	logic [3:0] ctrl;
	logic [31:0] tc;
	logic [31:0] pr;
	logic [31:0] pc;
	logic [MATCH_N*MCR_STRIDE-1:0] mcr;
	logic [3:0] cnt_ctrl;
	logic [CAP_MAX*CCR_STRIDE-1:0] ccr;
	logic [7:0] ext_act;
	logic [14:0] pwmc;
	logic [FLAG_W-1:0] flags;
	logic [CAP_N-1:0][31:0] cap;
	logic [CAP_MAX-1:0] cap_in;
	logic [CAP_MAX-1:0] cap_prev;
	logic [MATCH_N-1:0][31:0] shadow;
	logic [MATCH_N-1:0][31:0] active;
	logic [MATCH_N-1:0] pending;
	logic [MATCH_N-1:0] mhit;
	logic [MATCH_N-2:0] pwm_set;
	logic [MATCH_N-2:0] pwm_clr;
	logic [MATCH_N-2:0] next_pwm;
	logic [CAP_MAX-1:0] capev;
	logic [FLAG_W-1:0] flag_set;
	logic [FLAG_W-1:0] next_flags;
	logic [31:0] rd_mux;
	logic wr_take;
	logic run;
	logic pwm_mode;
	logic cnt_edge;
	logic step;
	logic tick;
	logic rst_hit;
	logic stop_hit;

	function automatic logic wr_to(input logic [7:0] off);
		return wr_take && av_i.address == off;
	endfunction : wr_to

	function automatic logic [31:0] wdat(input logic [31:0] old);
		return merge_bytes(old, av_i.writedata, av_i.byteenable);
	endfunction : wdat

	// ----------------------------------------------------------------
	// bus slave: one wait cycle, answer in the next
	// ----------------------------------------------------------------
	assign wr_take = bus_state == BUS_ACK && av_i.write;

	always_comb begin
		rd_mux = RST_WORD;
		case (av_i.address)
			OFF_CTRL: rd_mux = 32'(ctrl);
			OFF_COUNT: rd_mux = tc;
			OFF_PRESCALE: rd_mux = pr;
			OFF_PRECOUNT: rd_mux = pc;
			OFF_MATCH_CTRL: rd_mux = 32'(mcr);
			OFF_COUNT_CTRL: rd_mux = 32'(cnt_ctrl);
			OFF_CAP_CTRL: rd_mux = 32'(ccr);
			OFF_EXT_MATCH: rd_mux = 32'({ext_act, ext_match_o});
			OFF_PWM_CTRL: rd_mux = 32'(pwmc);
			OFF_RELEASE: rd_mux = 32'(pending);
			OFF_FLAGS: rd_mux = 32'(flags);
			default: begin
				for (int i = 0; i < MATCH_N; i++) begin
					if (av_i.address == OFF_MATCH_BASE + 8'(4 * i)) begin
						rd_mux = shadow[i];
					end
				end
				for (int c = 0; c < CAP_N; c++) begin
					if (av_i.address == OFF_CAP_BASE + 8'(4 * c)) begin
						rd_mux = cap[c];
					end
				end
			end
		endcase
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			bus_state <= BUS_IDLE;
			av_waitrequest_o <= 1'b1;
			av_readdata_o <= RST_WORD;
		end else begin
			unique case (bus_state)
				BUS_IDLE: begin
					if (av_i.read || av_i.write) begin
						bus_state <= BUS_ACK;
						av_waitrequest_o <= 1'b0;
						av_readdata_o <= av_i.read ? rd_mux : RST_WORD;
					end
				end
				BUS_ACK: begin
					bus_state <= BUS_IDLE;
					av_waitrequest_o <= 1'b1;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			pr <= RST_WORD;
			mcr <= '0;
			cnt_ctrl <= '0;
			ccr <= '0;
			ext_act <= '0;
			pwmc <= '0;
		end else begin
			if (wr_to(OFF_PRESCALE)) pr <= wdat(pr); // R01
			if (wr_to(OFF_MATCH_CTRL)) mcr <= 21'(wdat(32'(mcr)));
			if (wr_to(OFF_COUNT_CTRL)) cnt_ctrl <= 4'(wdat(32'(cnt_ctrl)));
			if (wr_to(OFF_CAP_CTRL)) ccr <= 12'(wdat(32'(ccr)));
			if (wr_to(OFF_EXT_MATCH)) begin
				ext_act <= 8'(wdat(32'(ext_act) << EMR_ACT_POS) >> EMR_ACT_POS);
			end
			if (wr_to(OFF_PWM_CTRL)) pwmc <= 15'(wdat(32'(pwmc)));
		end
	end

	// ----------------------------------------------------------------
	// run control and primary/secondary lock
	// ----------------------------------------------------------------
	// both ends count from the same registered enable
	assign pwm_mode = ctrl[CTRL_PWM];
	assign run = ctrl[CTRL_FOLLOW] ? sync_run_i : sync_run_o; // R15

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl <= '0;
			sync_run_o <= 1'b0;
		end else begin
			if (wr_to(OFF_CTRL)) begin
				ctrl <= 4'(wdat(32'(ctrl)));
			end else if (stop_hit) begin
				ctrl[CTRL_RUN] <= 1'b0; // R05
			end
			sync_run_o <= stop_hit ? 1'b0 : ctrl[CTRL_RUN]; // R15
		end
	end

	// ----------------------------------------------------------------
	// count source, prescaler and main count
	// ----------------------------------------------------------------
	always_comb begin
		cap_in = '0;
		cap_in[CAP_N-1:0] = cap_i;
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			cap_prev <= '0;
		end else begin
			cap_prev <= cap_in;
		end
	end

	always_comb begin
		logic cin;
		logic cpv;
		cin = cap_in[cnt_ctrl[CNT_SEL_POS +: 2]];
		cpv = cap_prev[cnt_ctrl[CNT_SEL_POS +: 2]];
		unique case (mbpwm_cnt_type'(cnt_ctrl[CNT_MODE_POS +: 2])) // R03
			CNT_TIMER: cnt_edge = 1'b1;
			CNT_RISE: cnt_edge = cin && !cpv;
			CNT_FALL: cnt_edge = !cin && cpv;
			CNT_BOTH: cnt_edge = cin != cpv;
		endcase
	end

	assign step = run && !ctrl[CTRL_CLR] && cnt_edge; // R03
	assign tick = step && pc == pr; // R02

	always_comb begin
		rst_hit = 1'b0;
		stop_hit = 1'b0;
		for (int i = 0; i < MATCH_N; i++) begin
			mhit[i] = tick && tc == active[i]; // R12
			rst_hit = rst_hit || (mhit[i] && mcr[MCR_STRIDE*i + MCR_RST]);
			stop_hit = stop_hit || (mhit[i] && mcr[MCR_STRIDE*i + MCR_STOP]);
		end
		rst_hit = rst_hit || (pwm_mode && mhit[0]); // R06
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			pc <= RST_WORD;
		end else if (ctrl[CTRL_CLR]) begin
			pc <= RST_WORD;
		end else if (wr_to(OFF_PRECOUNT)) begin
			pc <= wdat(pc);
		end else if (step) begin
			pc <= tick ? RST_WORD : pc + 32'h0000_0001; // R02
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			tc <= RST_WORD;
		end else if (ctrl[CTRL_CLR]) begin
			tc <= RST_WORD;
		end else if (wr_to(OFF_COUNT)) begin
			tc <= wdat(tc);
		end else if (tick) begin
			tc <= rst_hit ? RST_WORD : tc + 32'h0000_0001; // R01 R05 R06
		end
	end

	// ----------------------------------------------------------------
	// match values with release at cycle start
	// ----------------------------------------------------------------
	mbpwm_match_bank u_bank (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.wr_i(wr_take && av_i.address[7:5] == OFF_MATCH_BASE[7:5]),
		.idx_i(av_i.address[4:2]),
		.data_i(av_i.writedata),
		.be_i(av_i.byteenable),
		.rel_wr_i(wr_to(OFF_RELEASE)),
		.rel_i(av_i.writedata[MATCH_N-1:0]),
		.apply_i(mhit[0]),
		.now_i(!pwm_mode),
		.shadow_o(shadow),
		.active_o(active),
		.pending_o(pending)
	); // R13

	// ----------------------------------------------------------------
	// modulated outputs
	// ----------------------------------------------------------------
	// output n: single edge = set at cycle start, clear at match n;
	// double edge = set at match n-1, clear at match n, anywhere in cycle
	always_comb begin
		for (int n = 1; n < MATCH_N; n++) begin
			if (n > 1 && pwmc[PWM_DBL_POS + n]) begin
				pwm_set[n-1] = mhit[n-1]; // R09 R10 R11
			end else begin
				pwm_set[n-1] = mhit[0] && active[n] != RST_WORD; // R07 R08
			end
			pwm_clr[n-1] = mhit[n]; // R08 R09
			if (!(pwm_mode && pwmc[PWM_EN_POS + n])) begin
				next_pwm[n-1] = 1'b0; // R14
			end else if (pwm_clr[n-1]) begin
				next_pwm[n-1] = 1'b0;
			end else if (pwm_set[n-1]) begin
				next_pwm[n-1] = 1'b1;
			end else begin
				next_pwm[n-1] = pwm_o[n-1];
			end
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			pwm_o <= '0;
		end else begin
			pwm_o <= next_pwm; // R04
		end
	end

	// ----------------------------------------------------------------
	// external match outputs
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			ext_match_o <= '0;
		end else begin
			for (int i = 0; i < EXT_N; i++) begin
				if (wr_to(OFF_EXT_MATCH)) begin
					ext_match_o[i] <= av_i.writedata[i];
				end else if (mhit[i]) begin
					unique case (mbpwm_ext_type'(ext_act[2*i +: 2])) // R17
						EXT_KEEP: ext_match_o[i] <= ext_match_o[i];
						EXT_LOW: ext_match_o[i] <= 1'b0;
						EXT_HIGH: ext_match_o[i] <= 1'b1;
						EXT_TOGGLE: ext_match_o[i] <= !ext_match_o[i];
					endcase
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// capture channels
	// ----------------------------------------------------------------
	always_comb begin
		for (int c = 0; c < CAP_MAX; c++) begin
			capev[c] = c < CAP_N &&
				((cap_in[c] && !cap_prev[c] && ccr[CCR_STRIDE*c + CCR_RISE]) ||
				(!cap_in[c] && cap_prev[c] && ccr[CCR_STRIDE*c + CCR_FALL]));
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			cap <= '0;
		end else begin
			for (int c = 0; c < CAP_N; c++) begin
				if (capev[c]) begin
					cap[c] <= tc; // R16
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// event flags, write one to clear, set wins
	// ----------------------------------------------------------------
	always_comb begin
		flag_set = '0;
		for (int i = 0; i < MATCH_N; i++) begin
			flag_set[i] = mhit[i] && mcr[MCR_STRIDE*i + MCR_INT]; // R05
		end
		for (int c = 0; c < CAP_MAX; c++) begin
			flag_set[FLAG_CAP_POS + c] = capev[c] && ccr[CCR_STRIDE*c + CCR_INT]; // R16
		end
		next_flags = flags;
		if (wr_to(OFF_FLAGS)) begin
			next_flags = flags & ~av_i.writedata[FLAG_W-1:0];
		end
		next_flags = next_flags | flag_set;
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			flags <= '0;
			attn_o <= 1'b0;
		end else begin
			flags <= next_flags;
			attn_o <= |next_flags;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	sequence s_req;
		(av_i.read || av_i.write) && bus_state == BUS_IDLE;
	endsequence

	sequence s_ack;
		!av_waitrequest_o ##1 av_waitrequest_o;
	endsequence

	a_bus_answer: assert property (s_req |=> s_ack)
		else $error("bus answer not given after one wait cycle");

	a_prescale_wrap: assert property ( // R02
		tick && !ctrl[CTRL_CLR] && !wr_take |=> pc == RST_WORD)
		else $error("prescaler did not restart after terminal value");

	a_count_step: assert property ( // R01
		tick && !rst_hit && !ctrl[CTRL_CLR] && !wr_take
		|=> tc == $past(tc) + 32'h0000_0001)
		else $error("count did not advance on prescaler terminal");

	a_cycle_clear: assert property ( // R06
		pwm_mode && mhit[0] && !ctrl[CTRL_CLR] && !wr_take |=> tc == RST_WORD)
		else $error("cycle match did not clear the count");

	a_single_rise: assert property ( // R07
		pwm_mode && pwmc[PWM_EN_POS + 1] && mhit[0] && !mhit[1] &&
		active[1] != RST_WORD |=> pwm_o[0])
		else $error("single-edge output not high at cycle start");

	a_double_fall: assert property ( // R11
		pwm_mode && pwmc[PWM_EN_POS + 2] && pwmc[PWM_DBL_POS + 2] && mhit[2]
		|=> !pwm_o[1] ##1 (pwm_o[1] == $past(pwm_o[1]) || $past(mhit[1])))
		else $error("double-edge output edges wrong");

	a_stop_halt: assert property ( // R05
		stop_hit && !wr_to(OFF_CTRL) |=> !sync_run_o && !ctrl[CTRL_RUN])
		else $error("stop on match did not halt the count");

	a_capture_copy: assert property ( // R16
		capev[0] |=> cap[0] == $past(tc))
		else $error("capture did not copy the count");

	a_ext_toggle: assert property ( // R17
		mhit[0] && ext_act[1:0] == EXT_TOGGLE && !wr_to(OFF_EXT_MATCH)
		|=> ext_match_o[0] != $past(ext_match_o[0]))
		else $error("external match output did not toggle");

endmodule : mbpwm_top

// >>> dv/mbpwm_load.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// load on the modulated outputs: counts high samples of each output and rises of output zero
// ----------------------------------------------------------------
module mbpwm_load (
	input wire logic mclk_i,
	input wire logic win_i,
	input wire logic [5:0] pwm_i,
	output logic [5:0][31:0] hi_o,
	output logic [31:0] rise_o
);
	logic prev;

	always_ff @(posedge mclk_i) begin
		prev <= pwm_i[0];
	end

	// counters clear while the window is closed
	always_ff @(posedge mclk_i) begin
		if (!win_i) begin
			hi_o <= '0;
			rise_o <= '0;
		end else begin
			for (int k = 0; k < 6; k++) begin
				hi_o[k] <= hi_o[k] + {31'h0, pwm_i[k]};
			end
			if (pwm_i[0] && !prev) begin
				rise_o <= rise_o + 32'h1;
			end
		end
	end
endmodule : mbpwm_load

// >>> dv/testbench.sv
`timescale 1ns/1ps
module testbench;
	import mbpwm_pkg::*;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	mbpwm_avreq_type av = '0;
	logic [31:0] rdata;
	logic wreq;
	logic [3:0] cap = 4'h0;
	logic sync;
	logic prim = 1'b0;
	logic [5:0] pwm;
	logic [3:0] ext;
	logic attn;
	logic win = 1'b0;
	logic [5:0][31:0] hi;
	logic [31:0] rises;
	logic [31:0] got;
	logic [31:0] v;
	int bad_count = 0;
	int n_tests = 0;
	logic [31:0] pm [7] = '{32'h9, 32'h3, 32'h7, 32'h0, 32'h5, 32'hFF, 32'hFF};

	mbpwm_top #(.CAP_N(4)) uut (
		.mclk_i(mclk_i), .rst_i(rst_i), .av_i(av), .av_readdata_o(rdata),
		.av_waitrequest_o(wreq), .cap_i(cap), .sync_run_i(prim),
		.sync_run_o(sync), .pwm_o(pwm), .ext_match_o(ext), .attn_o(attn)
	);

	mbpwm_load load (
		.mclk_i(mclk_i), .win_i(win), .pwm_i(pwm), .hi_o(hi), .rise_o(rises)
	);

	initial begin
		forever #5 mclk_i = ~mclk_i;
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic complete_run();
		if (bad_count == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : complete_run

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value at %0t: got %h, expected %h", $time, g, e);
		end
	endtask : chk

	task automatic access(input logic rd, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk_i);
		av <= '{read: rd, write: !rd, address: a, byteenable: 4'hF,
			writedata: d};
		do begin
			@(posedge mclk_i);
			n++;
		end while (wreq !== 1'b0 && n < 20);
		got = rdata;
		av <= '0;
		if (wreq !== 1'b0) begin
			bad_count++;
			$display("wrong value at %0t: got %h, expected %h", $time, wreq, 1'b0);
			complete_run();
		end
	endtask : access

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		access(1'b0, a, d);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		access(1'b1, a, 32'h0);
		chk(got, e);
	endtask : rd

	task automatic pulse(input int n);
		repeat (n) begin
			@(posedge mclk_i);
			cap <= 4'h1;
			repeat (3) @(posedge mclk_i);
			cap <= 4'h0;
			repeat (3) @(posedge mclk_i);
		end
	endtask : pulse

	task automatic measure(input logic [31:0] h1, input logic [31:0] h2);
		repeat (20) @(posedge mclk_i);
		win <= 1'b1;
		repeat (100) @(posedge mclk_i);
		#1;
		chk(hi[0], h1);
		chk(hi[1], h2);
		chk(hi[2], 32'h0);
		chk(hi[3], 32'h0);
		chk(hi[4] | hi[5], 32'h0);
		chk(rises, 32'hA);
		win <= 1'b0;
	endtask : measure

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (5) @(posedge mclk_i);
		rst_i <= 1'b0;
		rd(OFF_CTRL, RST_WORD);
		rd(OFF_COUNT, RST_WORD);
		rd(8'hFC, 32'h0);
		// stop on match zero, toggle external output zero
		wr(OFF_PRESCALE, 32'h2);
		wr(OFF_MATCH_BASE, 32'h5);
		for (int i = 1; i < 7; i++) begin
			wr(OFF_MATCH_BASE + 8'(4 * i), 32'hFF);
		end
		wr(OFF_MATCH_CTRL, 32'h5);
		wr(OFF_EXT_MATCH, 32'h30);
		wr(OFF_CTRL, 32'h1);
		for (int n = 0; n < 200 && attn !== 1'b1; n++) begin
			@(posedge mclk_i);
		end
		chk({31'h0, attn}, 32'h1);
		if (attn !== 1'b1) begin
			complete_run();
		end
		rd(OFF_CTRL, 32'h0);
		chk({31'h0, sync}, 32'h0);
		rd(OFF_FLAGS, 32'h1);
		rd(OFF_EXT_MATCH, 32'h31);
		chk({28'h0, ext}, 32'h1);
		// capture while stopped
		access(1'b1, OFF_COUNT, 32'h0);
		v = got;
		wr(OFF_CAP_CTRL, 32'h5);
		pulse(1);
		rd(OFF_CAP_BASE, v);
		rd(OFF_FLAGS, 32'h81);
		wr(OFF_FLAGS, 32'h7FF);
		rd(OFF_FLAGS, 32'h0);
		chk({31'h0, attn}, 32'h0);
		// counter mode through the prescaler
		wr(OFF_CTRL, 32'h2);
		wr(OFF_CAP_CTRL, 32'h0);
		wr(OFF_MATCH_CTRL, 32'h0);
		wr(OFF_COUNT_CTRL, 32'h1);
		wr(OFF_CTRL, 32'h1);
		pulse(7);
		rd(OFF_COUNT, 32'h2);
		rd(OFF_PRECOUNT, 32'h1);
		// follow mode: count only while the primary enable is high
		wr(OFF_CTRL, 32'h9);
		pulse(3);
		rd(OFF_COUNT, 32'h2);
		prim <= 1'b1;
		pulse(3);
		rd(OFF_COUNT, 32'h3);
		prim <= 1'b0;
		// modulation: single, double and held-low outputs
		wr(OFF_CTRL, 32'h2);
		wr(OFF_COUNT_CTRL, 32'h0);
		wr(OFF_PRESCALE, 32'h0);
		wr(OFF_MATCH_CTRL, 32'h2);
		for (int i = 0; i < 7; i++) begin
			wr(OFF_MATCH_BASE + 8'(4 * i), pm[i]);
		end
		wr(OFF_PWM_CTRL, 32'h0E04);
		wr(OFF_RELEASE, 32'h7F);
		wr(OFF_CTRL, 32'h5);
		measure(32'h28, 32'h28);
		chk({31'h0, sync}, 32'h1);
		wr(OFF_MATCH_BASE + 8'h8, 32'h1);
		rd(OFF_MATCH_BASE + 8'h8, 32'h1);
		measure(32'h28, 32'h28);
		wr(OFF_RELEASE, 32'h4);
		measure(32'h28, 32'h50);
		complete_run();
	end
endmodule : testbench
